// ### rtl/dpa_pkg.sv
// shared constants and types for the dual parallel port adapter
package dpa_pkg;

   localparam int         DPA_W          = 8;
   localparam int         DPA_SYNC_W     = 35;

   // register-select codes
   localparam logic [1:0] DPA_SEL_PORT_A = 2'h0;
   localparam logic [1:0] DPA_SEL_CTRL_A = 2'h1;
   localparam logic [1:0] DPA_SEL_PORT_B = 2'h2;
   localparam logic [1:0] DPA_SEL_CTRL_B = 2'h3;

   // control register field positions
   localparam int         DPA_CR_EN1     = 0;
   localparam int         DPA_CR_POL1    = 1;
   localparam int         DPA_CR_ACCESS  = 2;
   localparam int         DPA_CR_EN2     = 3;
   localparam int         DPA_CR_POL2    = 4;
   localparam int         DPA_CR_MODE2   = 5;
   localparam int         DPA_CR_CFG_W   = 6;

   // reset values
   localparam logic [7:0] DPA_RST_BYTE   = 8'h00;
   localparam logic [5:0] DPA_RST_CFG    = 6'h00;
   localparam logic [1:0] DPA_RST_FLAGS  = 2'h0;

   // open-drain request pin never drives high
   localparam logic       DPA_IRQ_LEVEL  = 1'b0;

   typedef enum {DPA_PH_LOW, DPA_PH_HIGH} dpa_phase_t;

endpackage

// ### rtl/dpa_side_if.sv
// signals between the bus core and one side's interrupt status logic
`timescale 1ns/10ps
`default_nettype none
interface dpa_side_if;
   import dpa_pkg::*;
   logic                    edge_one;
   logic                    edge_two;
   logic [DPA_CR_CFG_W-1:0] cfg;
   logic                    clear;
   logic [1:0]              flags;
   logic                    irq_n;

   modport core (output edge_one, edge_two, cfg, clear,
                 input  flags, irq_n);
   modport side (input  edge_one, edge_two, cfg, clear,
                 output flags, irq_n);
endinterface
`default_nettype wire

// ### rtl/dpa_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module dpa_sync
   import dpa_pkg::*;
#(
   parameter int W = DPA_SYNC_W
)
(
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_nxt;

   // first stage feeds only the second stage
   always_comb
   begin
      meta_nxt = d;
      q_nxt    = meta_r;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         meta_r <= '0;
         q      <= '0;
      end
      else
      begin
         meta_r <= meta_nxt;
         q      <= q_nxt;
      end
   end

endmodule
`default_nettype wire

// ### rtl/dpa_irq_side.sv
// interrupt status logic for one side: edge detect, flags, request
`timescale 1ns/10ps
`default_nettype none
module dpa_irq_side
   import dpa_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst_n,
   dpa_side_if.side  sif
);

   logic [1:0] prev_r;
   logic [1:0] prev_nxt;
   logic [1:0] flag_r;
   logic [1:0] flag_nxt;
   logic       irq_n_r;
   logic       irq_n_nxt;
   logic       act_one;
   logic       act_two;

   always_comb
   begin
      prev_nxt = {sif.edge_one, sif.edge_two};
      // polarity bit one selects rising edge, zero falling
      act_one  = sif.cfg[DPA_CR_POL1] ? (sif.edge_one & ~prev_r[1])
                                      : (~sif.edge_one & prev_r[1]);
      act_two  = sif.cfg[DPA_CR_POL2] ? (sif.edge_two & ~prev_r[0])
                                      : (~sif.edge_two & prev_r[0]);
      // second line only flags while configured as an input
      act_two  = act_two & ~sif.cfg[DPA_CR_MODE2];
      // a new edge beats a clearing read in the same cycle
      flag_nxt[1] = act_one | (flag_r[1] & ~sif.clear);
      flag_nxt[0] = act_two | (flag_r[0] & ~sif.clear);
      // pull low while an enabled flag stands
      irq_n_nxt = ~((flag_nxt[1] & sif.cfg[DPA_CR_EN1]) |
                    (flag_nxt[0] & sif.cfg[DPA_CR_EN2]));
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         prev_r  <= DPA_RST_FLAGS;
         flag_r  <= DPA_RST_FLAGS;
         irq_n_r <= 1'b1;
      end
      else
      begin
         prev_r  <= prev_nxt;
         flag_r  <= flag_nxt;
         irq_n_r <= irq_n_nxt;
      end
   end

   assign sif.flags = flag_r;
   assign sif.irq_n = irq_n_r;

   ////////////////////////////////////////////////////////////////////////
   flag_on_edge_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (sif.cfg[DPA_CR_POL1] && sif.edge_one && !prev_r[1]) |=> flag_r[1])
      else $error("edge did not set status flag");

   read_clears_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (sif.clear && flag_r[1] && !act_one) |=> !flag_r[1])
      else $error("port read did not clear status flag");

   irq_follows_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      irq_n_r == !((flag_r[1] && $past(sif.cfg[DPA_CR_EN1])) ||
                   (flag_r[0] && $past(sif.cfg[DPA_CR_EN2]))))
      else $error("request pin disagrees with flags and enables");

   irq_seen_c : cover property (
      @(posedge sys_clk) disable iff (!rst_n) $fell(irq_n_r));

endmodule
`default_nettype wire

// ### rtl/dpa_top.sv
// dual parallel port adapter: host bus, two peripheral sides
// Behaviour
// - reset low clears control, direction and output registers
// - host transfers happen only around the phase-two clock
// - read/write high reads the device, low writes it
// - each side has an active-low open-drain request output
// - data bus undriven except while selected for a read
// - access needs both high selects high and low select low
// - write data latched in phase two, stored after its fall
// - control bit 2 picks output register (1) or direction (0)
// - select 00 port A, 01 control A, 10 port B, 11 control B
// - direction bit one makes a line output, zero input
// - output lines follow the output register bits
// - host writes all registers, reads control and direction back
// - control bits 6 and 7 show the two interrupt flags
// - side A output register does not touch input lines
// - side A port read returns sampled pin levels
// - read at 00 with control A bit 2 set gives A pins
// - side B read gives register for outputs, pins for inputs
// - status logic flags configured edges on both inputs
// - port read clears both flags of that side
// - request low when flag 7 and bit 0, or 6 and bit 3
// - the two sides hold independent registers and status
`timescale 1ns/10ps
`default_nettype none
module dpa_top
   import dpa_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic             phase_two,
   input  wire logic             select_high_first,
   input  wire logic             select_high_second,
   input  wire logic             select_low_third_n,
   input  wire logic             reg_pick_low,
   input  wire logic             reg_pick_high,
   input  wire logic             read_not_write,
   input  wire logic [DPA_W-1:0] data_in,
   output var  logic [DPA_W-1:0] data_out,
   output var  logic             data_oe_n,
   input  wire logic [DPA_W-1:0] port_side_a_lines_in,
   output var  logic [DPA_W-1:0] port_side_a_lines_out,
   output var  logic [DPA_W-1:0] port_side_a_lines_oe_n,
   input  wire logic [DPA_W-1:0] port_side_b_lines_in,
   output var  logic [DPA_W-1:0] port_side_b_lines_out,
   output var  logic [DPA_W-1:0] port_side_b_lines_oe_n,
   input  wire logic             edge_input_a_one,
   input  wire logic             edge_input_a_two,
   input  wire logic             edge_input_b_one,
   input  wire logic             edge_input_b_two,
   output var  logic             interrupt_out_side_a_out,
   output var  logic             interrupt_out_side_a_oe_n,
   output var  logic             interrupt_out_side_b_out,
   output var  logic             interrupt_out_side_b_oe_n
);

   ////////////////////////////////////////////////////////////////////////
   // every pin passes two flops before use
   logic [DPA_SYNC_W-1:0] pin_raw;
   logic [DPA_SYNC_W-1:0] pin_s;
   logic                  phi2_s;
   logic                  cs0_s;
   logic                  cs1_s;
   logic                  cs2_n_s;
   logic [1:0]            rs_s;
   logic                  rw_s;
   logic [DPA_W-1:0]      din_s;
   logic [DPA_W-1:0]      pa_s;
   logic [DPA_W-1:0]      pb_s;
   logic [3:0]            edge_s;

   assign pin_raw = {phase_two, select_high_first, select_high_second,
                     select_low_third_n, reg_pick_high, reg_pick_low,
                     read_not_write, data_in, port_side_a_lines_in,
                     port_side_b_lines_in, edge_input_a_one,
                     edge_input_a_two, edge_input_b_one, edge_input_b_two};

   dpa_sync #(
      .W       (DPA_SYNC_W)
   ) u_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .d       (pin_raw),
      .q       (pin_s)
   );

   assign {phi2_s, cs0_s, cs1_s, cs2_n_s, rs_s, rw_s, din_s,
           pa_s, pb_s, edge_s} = pin_s;

   ////////////////////////////////////////////////////////////////////////
   // register state
   dpa_phase_t               ph_r;
   dpa_phase_t               ph_nxt;
   logic                     cap_sel_r;
   logic                     cap_sel_nxt;
   logic                     cap_rw_r;
   logic                     cap_rw_nxt;
   logic [1:0]               cap_rs_r;
   logic [1:0]               cap_rs_nxt;
   logic [DPA_W-1:0]         cap_data_r;
   logic [DPA_W-1:0]         cap_data_nxt;
   logic [DPA_CR_CFG_W-1:0]  cra_r;
   logic [DPA_CR_CFG_W-1:0]  cra_nxt;
   logic [DPA_CR_CFG_W-1:0]  crb_r;
   logic [DPA_CR_CFG_W-1:0]  crb_nxt;
   logic [DPA_W-1:0]         direction_a_r;
   logic [DPA_W-1:0]         direction_a_nxt;
   logic [DPA_W-1:0]         direction_b_r;
   logic [DPA_W-1:0]         direction_b_nxt;
   logic [DPA_W-1:0]         ora_r;
   logic [DPA_W-1:0]         ora_nxt;
   logic [DPA_W-1:0]         orb_r;
   logic [DPA_W-1:0]         orb_nxt;
   logic [DPA_W-1:0]         dout_r;
   logic [DPA_W-1:0]         dout_nxt;
   logic                     doe_n_r;
   logic                     doe_n_nxt;
   logic [DPA_W-1:0]         pa_oe_n_r;
   logic [DPA_W-1:0]         pb_oe_n_r;
   logic                     sel;
   logic                     fall;
   logic                     commit_wr;
   logic                     commit_rd;
   logic                     clear_a;
   logic                     clear_b;
   logic [DPA_W-1:0]         pb_read;

   dpa_side_if sif_a ();
   dpa_side_if sif_b ();

   // each side keeps its own status logic
   dpa_irq_side u_side_a (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .sif     (sif_a)
   );

   dpa_irq_side u_side_b (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .sif     (sif_b)
   );

   assign sif_a.edge_one = edge_s[3];
   assign sif_a.edge_two = edge_s[2];
   assign sif_b.edge_one = edge_s[1];
   assign sif_b.edge_two = edge_s[0];
   assign sif_a.cfg      = cra_r;
   assign sif_b.cfg      = crb_r;
   assign sif_a.clear    = clear_a;
   assign sif_b.clear    = clear_b;

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      // chip select decode
      sel          = cs0_s & cs1_s & ~cs2_n_s;
      ph_nxt       = ph_r;
      fall         = 1'b0;
      cap_sel_nxt  = cap_sel_r;
      cap_rw_nxt   = cap_rw_r;
      cap_rs_nxt   = cap_rs_r;
      cap_data_nxt = cap_data_r;
      // bus cycle framed by phase two
      case (ph_r)
         DPA_PH_LOW:
         begin
            if (phi2_s)
            begin
               ph_nxt = DPA_PH_HIGH;
            end
         end
         DPA_PH_HIGH:
         begin
            if (!phi2_s)
            begin
               ph_nxt = DPA_PH_LOW;
               fall   = 1'b1;
            end
         end
         default:
         begin
            ph_nxt = DPA_PH_LOW;
         end
      endcase
      // latch bus while phase two is high; last sample wins
      if (phi2_s)
      begin
         cap_sel_nxt  = sel;
         cap_rw_nxt   = rw_s;
         cap_rs_nxt   = rs_s;
         cap_data_nxt = din_s;
      end
      // direction read high/low
      commit_wr = fall & cap_sel_r & ~cap_rw_r;
      commit_rd = fall & cap_sel_r & cap_rw_r;
      clear_a   = commit_rd & (cap_rs_r == DPA_SEL_PORT_A) &
                  cra_r[DPA_CR_ACCESS];
      clear_b   = commit_rd & (cap_rs_r == DPA_SEL_PORT_B) &
                  crb_r[DPA_CR_ACCESS];

      cra_nxt  = cra_r;
      crb_nxt  = crb_r;
      direction_a_nxt = direction_a_r;
      direction_b_nxt = direction_b_r;
      ora_nxt  = ora_r;
      orb_nxt  = orb_r;
      // stored only after phase two falls
      if (commit_wr)
      begin
         if (cap_rs_r == DPA_SEL_PORT_A)
         begin
            if (cra_r[DPA_CR_ACCESS])
               ora_nxt = cap_data_r;
            else
               direction_a_nxt = cap_data_r;
         end
         else if (cap_rs_r == DPA_SEL_CTRL_A)
         begin
            // flag bits are read-only
            cra_nxt = cap_data_r[DPA_CR_CFG_W-1:0];
         end
         else if (cap_rs_r == DPA_SEL_PORT_B)
         begin
            if (crb_r[DPA_CR_ACCESS])
               orb_nxt = cap_data_r;
            else
               direction_b_nxt = cap_data_r;
         end
         else
         begin
            crb_nxt = cap_data_r[DPA_CR_CFG_W-1:0];
         end
      end

      // side B outputs read back from the register
      pb_read   = (orb_r & direction_b_r) | (pb_s & ~direction_b_r);
      // drive only while selected for a read in phase two
      doe_n_nxt = ~(phi2_s & sel & rw_s);
      dout_nxt  = dout_r;
      if (phi2_s & sel & rw_s)
      begin
         if (rs_s == DPA_SEL_PORT_A)
         begin
            // pins, not the register, are returned
            dout_nxt = cra_r[DPA_CR_ACCESS] ? pa_s : direction_a_r;
         end
         else if (rs_s == DPA_SEL_CTRL_A)
         begin
            dout_nxt = {sif_a.flags, cra_r};
         end
         else if (rs_s == DPA_SEL_PORT_B)
         begin
            dout_nxt = crb_r[DPA_CR_ACCESS] ? pb_read : direction_b_r;
         end
         else
         begin
            dout_nxt = {sif_b.flags, crb_r};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         // everything resets while reset is low, to zero except cap_rw_r and the output enables
         ph_r       <= DPA_PH_LOW;
         cap_sel_r  <= 1'b0;
         cap_rw_r   <= 1'b1;
         cap_rs_r   <= DPA_SEL_PORT_A;
         cap_data_r <= DPA_RST_BYTE;
         cra_r      <= DPA_RST_CFG;
         crb_r      <= DPA_RST_CFG;
         direction_a_r     <= DPA_RST_BYTE;
         direction_b_r     <= DPA_RST_BYTE;
         ora_r      <= DPA_RST_BYTE;
         orb_r      <= DPA_RST_BYTE;
         dout_r     <= DPA_RST_BYTE;
         doe_n_r    <= 1'b1;
         pa_oe_n_r  <= ~DPA_RST_BYTE;
         pb_oe_n_r  <= ~DPA_RST_BYTE;
      end
      else
      begin
         ph_r       <= ph_nxt;
         cap_sel_r  <= cap_sel_nxt;
         cap_rw_r   <= cap_rw_nxt;
         cap_rs_r   <= cap_rs_nxt;
         cap_data_r <= cap_data_nxt;
         cra_r      <= cra_nxt;
         crb_r      <= crb_nxt;
         direction_a_r     <= direction_a_nxt;
         direction_b_r     <= direction_b_nxt;
         ora_r      <= ora_nxt;
         orb_r      <= orb_nxt;
         dout_r     <= dout_nxt;
         doe_n_r    <= doe_n_nxt;
         // direction one enables the driver
         pa_oe_n_r  <= ~direction_a_nxt;
         pb_oe_n_r  <= ~direction_b_nxt;
      end
   end

   // output lines carry the register value when enabled
   assign port_side_a_lines_out     = ora_r;
   assign port_side_a_lines_oe_n    = pa_oe_n_r;
   assign port_side_b_lines_out     = orb_r;
   assign port_side_b_lines_oe_n    = pb_oe_n_r;
   assign data_out                  = dout_r;
   assign data_oe_n                 = doe_n_r;
   // open drain: only ever pulls low
   assign interrupt_out_side_a_out  = DPA_IRQ_LEVEL;
   assign interrupt_out_side_a_oe_n = sif_a.irq_n;
   assign interrupt_out_side_b_out  = DPA_IRQ_LEVEL;
   assign interrupt_out_side_b_oe_n = sif_b.irq_n;

   ////////////////////////////////////////////////////////////////////////
   reset_clears_a : assert property (
      @(posedge sys_clk)
      !rst_n |=> (cra_r == DPA_RST_CFG && ora_r == DPA_RST_BYTE &&
                  direction_a_r == DPA_RST_BYTE && crb_r == DPA_RST_CFG &&
                  direction_b_r == DPA_RST_BYTE && orb_r == DPA_RST_BYTE))
      else $error("registers not cleared by reset");

   bus_drive_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      !doe_n_r |-> $past(phi2_s && sel && rw_s))
      else $error("data bus driven outside a selected read");

   select_gate_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      $past(!cs0_s || !cs1_s || cs2_n_s) |-> doe_n_r)
      else $error("data bus driven without chip select");

   late_store_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      ($changed(ora_r) || $changed(direction_a_r) || $changed(crb_r))
         |-> $past(fall))
      else $error("register changed outside phase-two fall");

   steer_write_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (commit_wr && cap_rs_r == DPA_SEL_PORT_A && !cra_r[DPA_CR_ACCESS])
         |=> (direction_a_r == $past(cap_data_r)) && $stable(ora_r))
      else $error("direction write went astray");

   dir_enable_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (pa_oe_n_r == ~direction_a_r) && (pb_oe_n_r == ~direction_b_r))
      else $error("line enables disagree with direction");

   mixed_read_a : assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (phi2_s && sel && rw_s && rs_s == DPA_SEL_PORT_B &&
       crb_r[DPA_CR_ACCESS]) ##1 $stable(orb_r) && $stable(direction_b_r)
         |-> dout_r == ((orb_r & direction_b_r) | ($past(pb_s) & ~direction_b_r)))
      else $error("side B read returned wrong mix");

   write_seen_c : cover property (
      @(posedge sys_clk) disable iff (!rst_n) commit_wr);

   port_clear_c : cover property (
      @(posedge sys_clk) disable iff (!rst_n) clear_a || clear_b);

   read_seen_c : cover property (
      @(posedge sys_clk) disable iff (!rst_n) $fell(doe_n_r));

endmodule
`default_nettype wire

// ### tb/dpa_periph_model.sv
// peripheral pins facing both ports of the adapter
`timescale 1ns/10ps
`default_nettype none
module dpa_periph_model
#(
   parameter logic [7:0] EXT_A = 8'h3C,
   parameter logic [7:0] EXT_B = 8'h3C
)
(
   input  wire logic [7:0] a_out,
   input  wire logic [7:0] a_oe_n,
   input  wire logic [7:0] b_out,
   input  wire logic [7:0] b_oe_n,
   input  wire logic       load,
   output var  logic [7:0] a_pin,
   output var  logic [7:0] b_pin
);
   // a heavy load pulls driven lines low, so pins and register can differ
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         a_pin[i] = a_oe_n[i] ? EXT_A[i] : (a_out[i] & ~load);
         b_pin[i] = b_oe_n[i] ? EXT_B[i] : (b_out[i] & ~load);
      end
   end
endmodule
`default_nettype wire

// ### tb/test_dual_parallel_port_adapter.sv
// self-checking bench for the dual parallel port adapter
`timescale 1ns/10ps
`default_nettype none
module test_dual_parallel_port_adapter;
   import dpa_pkg::*;
   typedef struct packed
   {
      logic [2:0] sel;
      logic [1:0] rs;
      logic       rw;
      logic [7:0] wd;
      logic [7:0] ex;
   } dpa_row_t;
   logic       sys_clk, rst_n, ph2, rw, rpl, rph, ld, seen;
   logic       e_a1, e_a2, e_b1, e_b2, d_oe_n, irq_a, irq_b;
   logic       ia_out, ia_oe_n, ib_out, ib_oe_n;
   logic [2:0] sel;
   logic [7:0] host_d, bus_d, d_out, rd, a_in, a_out, a_oe_n;
   logic [7:0] b_in, b_out, b_oe_n;
   int         failures, num_checks;
   dpa_row_t   rows [17];
   ////////////////////////////////////////////////////////////////////////
   // host releases the bus while the adapter drives it
   assign bus_d = d_oe_n ? host_d : d_out;
   // request lines are pulled up when nobody sinks them
   assign irq_a = ia_oe_n ? 1'b1 : ia_out;
   assign irq_b = ib_oe_n ? 1'b1 : ib_out;
   dpa_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .phase_two(ph2),
      .select_high_first(sel[2]), .select_high_second(sel[1]),
      .select_low_third_n(sel[0]), .reg_pick_low(rpl),
      .reg_pick_high(rph), .read_not_write(rw), .data_in(bus_d),
      .data_out(d_out), .data_oe_n(d_oe_n),
      .port_side_a_lines_in(a_in), .port_side_a_lines_out(a_out),
      .port_side_a_lines_oe_n(a_oe_n), .port_side_b_lines_in(b_in),
      .port_side_b_lines_out(b_out), .port_side_b_lines_oe_n(b_oe_n),
      .edge_input_a_one(e_a1), .edge_input_a_two(e_a2),
      .edge_input_b_one(e_b1), .edge_input_b_two(e_b2),
      .interrupt_out_side_a_out(ia_out),
      .interrupt_out_side_a_oe_n(ia_oe_n),
      .interrupt_out_side_b_out(ib_out),
      .interrupt_out_side_b_oe_n(ib_oe_n));
   dpa_periph_model u_periph (.a_out(a_out), .a_oe_n(a_oe_n),
      .b_out(b_out), .b_oe_n(b_oe_n), .load(ld), .a_pin(a_in),
      .b_pin(b_in));
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task close_out;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] sv, input logic [7:0] ev);
      num_checks++;
      if (sv !== ev)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, ev, sv);
      end
   endtask
   // one phase-two pulse: five clocks high, five low, selects dropped to zero while low
   task bus(input logic [2:0] s, input logic [1:0] r, input logic w,
            input logic [7:0] wd);
      sel = s;
      {rph, rpl} = r;
      rw = w;
      host_d = wd;
      ph2 = 1'b1;
      seen = 1'b0;
      rd = 8'h00;
      for (int i = 0; i < 5; i++)
      begin
         tick(1);
         if (d_oe_n === 1'b0)
         begin
            seen = 1'b1;
            rd = bus_d;
         end
      end
      ph2 = 1'b0;
      sel = 3'h0;
      tick(5);
      chk("bus release", {7'h00, d_oe_n}, 8'h01);
   endtask
   task wait_low(input logic b);
      int k;
      k = 0;
      while ((b ? irq_b : irq_a) !== 1'b0 && k < 10)
      begin
         tick(1);
         k++;
      end
      if ((b ? irq_b : irq_a) !== 1'b0)
      begin
         failures++;
         close_out();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      {rst_n, ph2, sel, rw, rpl, rph, host_d} = '0;
      {e_a1, e_a2, e_b1, e_b2} = 4'h0;
      ld = 1'b1;
      failures = 0;
      num_checks = 0;
      rows = '{'{3'h6, 2'h1, 1'b1, 8'h00, 8'h00},
               '{3'h6, 2'h0, 1'b0, 8'hF0, 8'h00},
               '{3'h6, 2'h1, 1'b0, 8'hC4, 8'h00},
               '{3'h6, 2'h1, 1'b1, 8'h00, 8'h04},
               '{3'h6, 2'h0, 1'b0, 8'hA5, 8'h00},
               '{3'h6, 2'h0, 1'b1, 8'h00, 8'h0C},
               '{3'h6, 2'h1, 1'b0, 8'h00, 8'h00},
               '{3'h6, 2'h0, 1'b1, 8'h00, 8'hF0},
               '{3'h6, 2'h1, 1'b0, 8'h04, 8'h00},
               '{3'h6, 2'h2, 1'b0, 8'h0F, 8'h00},
               '{3'h6, 2'h3, 1'b0, 8'h04, 8'h00},
               '{3'h6, 2'h2, 1'b0, 8'h5A, 8'h00},
               '{3'h6, 2'h2, 1'b1, 8'h00, 8'h3A},
               '{3'h2, 2'h3, 1'b0, 8'h00, 8'h00},
               '{3'h4, 2'h3, 1'b0, 8'h00, 8'h00},
               '{3'h7, 2'h3, 1'b1, 8'h00, 8'h00},
               '{3'h6, 2'h3, 1'b1, 8'h00, 8'h04}};
      tick(10);
      chk("a oe_n in reset", a_oe_n, 8'hFF);
      rst_n = 1'b1;
      tick(1);
      foreach (rows[i])
      begin
         bus(rows[i].sel, rows[i].rs, rows[i].rw, rows[i].wd);
         if (rows[i].rw && rows[i].sel == 3'h6)
            chk("read data", rd, rows[i].ex);
         chk("drove bus", {7'h00, seen},
             {7'h00, rows[i].rw && rows[i].sel == 3'h6});
      end
      chk("a out", a_out, 8'hA5);
      chk("a oe_n", a_oe_n, 8'h0F);
      chk("b oe_n", b_oe_n, 8'hF0);
      chk("b out", b_out, 8'h5A);
      // rising edge on side A input one, request enabled
      bus(3'h6, 2'h1, 1'b0, 8'h07);
      e_a1 = 1'b1;
      wait_low(1'b0);
      chk("irq b idle", {7'h00, irq_b}, 8'h01);
      chk("irq a level", {7'h00, ia_out}, 8'h00);
      bus(3'h6, 2'h1, 1'b1, 8'h00);
      chk("flag a", rd, 8'h87);
      bus(3'h6, 2'h0, 1'b1, 8'h00);
      tick(2);
      chk("irq a clear", {7'h00, irq_a}, 8'h01);
      bus(3'h6, 2'h1, 1'b1, 8'h00);
      chk("flag a clear", rd, 8'h07);
      // side B input two, then its enable withdrawn
      bus(3'h6, 2'h3, 1'b0, 8'h1C);
      e_b2 = 1'b1;
      wait_low(1'b1);
      chk("irq a idle", {7'h00, irq_a}, 8'h01);
      bus(3'h6, 2'h3, 1'b1, 8'h00);
      chk("flag b", rd, 8'h5C);
      bus(3'h6, 2'h3, 1'b0, 8'h14);
      tick(2);
      chk("irq b off", {7'h00, irq_b}, 8'h01);
      bus(3'h6, 2'h3, 1'b1, 8'h00);
      chk("flag b kept", rd, 8'h54);
      // side A: second line in output mode, then falling edge on line one
      bus(3'h6, 2'h1, 1'b0, 8'h3C);
      e_a2 = 1'b1;
      tick(4);
      chk("mode2 no irq", {7'h00, irq_a}, 8'h01);
      bus(3'h6, 2'h1, 1'b1, 8'h00);
      chk("mode2 no flag", rd, 8'h3C);
      bus(3'h6, 2'h1, 1'b0, 8'h05);
      e_a1 = 1'b0;
      wait_low(1'b0);
      bus(3'h6, 2'h1, 1'b1, 8'h00);
      chk("fall flag a", rd, 8'h85);
      // second reset in mid-run
      rst_n = 1'b0;
      tick(10);
      chk("b oe_n reset", b_oe_n, 8'hFF);
      chk("irq b reset", {7'h00, ib_oe_n}, 8'h01);
      rst_n = 1'b1;
      tick(1);
      bus(3'h6, 2'h3, 1'b1, 8'h00);
      chk("ctrl b reset", rd, 8'h00);
      close_out();
   end
endmodule
`default_nettype wire
